/* verilog/pasm_pkg.sv */
// Purpose: constants for the port-4 analog share pin mux
// Assumes: axi4-lite, 32-bit data, registers one word each
// Notes:   byte address is four times the register index
// Behaviour
// R1: at most one pin routed to converter
// R2: analog-only bit isolates digital path
// R3: analog-only bit clear allows either use
// R4: analog-only field bits 4:0, reset zero
// R5: channel enable low keeps all digital
// R6: channel enable high forces selected pin analog
// R7: selector 000..101 picks inputs 0..5
// R8: input n maps to pin n
// R9: external reference enable takes pin 0
// R10: software disables channel before digital use
// R11: software writes latch before direction output
// R12: active channel needs converter and channel enable
// R13: direction 1 drives, 0 inputs
// R14: isolated pin reads fixed zero
package pasm_pkg;
	localparam int          PASM_NPINS          = 5;
	localparam logic [7:0]  PASM_IDX_ANALOG     = 8'hae;
	localparam logic [7:0]  PASM_IDX_HREF       = 8'haf;
	localparam logic [7:0]  PASM_IDX_MODE       = 8'hb1;
	localparam logic [7:0]  PASM_IDX_DATA       = 8'hd4;
	localparam logic [7:0]  PASM_IDX_DIR        = 8'hc4;
	localparam logic [7:0]  PASM_IDX_STATUS     = 8'hc0;
	localparam int          PASM_MODE_CONV_BIT  = 7;
	localparam int          PASM_MODE_GCH_BIT   = 4;
	localparam int          PASM_HREF_EN_BIT    = 7;
	localparam logic [7:0]  PASM_MODE_MASK      = 8'hf7;
	localparam logic [7:0]  PASM_HREF_MASK      = 8'h83;
	localparam logic [7:0]  PASM_RESET_VAL      = 8'h00;
	localparam logic [2:0]  PASM_SEL_MAX        = 3'h5;
	localparam logic [1:0]  PASM_RESP_OKAY      = 2'h0;
	localparam logic [1:0]  PASM_RESP_SLVERR    = 2'h2;
	localparam logic        PASM_ISOLATED_READ  = 1'b0;
endpackage : pasm_pkg

/* verilog/pasm_sel_if.sv */
`timescale 1ns/1ps
// Purpose: carries pin configuration to the pin decoder
// Assumes: one clock domain
// Notes:   combinational decode results come back
interface pasm_sel_if #(parameter int NPINS = 5);
	logic [NPINS-1:0] analog_only;
	logic [2:0]       chan_sel;
	logic             gch_en;
	logic             conv_en;
	logic             href_en;
	logic [NPINS-1:0] ain_sel;
	logic [NPINS-1:0] dig_ok;
	logic             href_conn;
	logic             sel_valid;
	modport ctrl (output analog_only, chan_sel, gch_en, conv_en, href_en,
		input ain_sel, dig_ok, href_conn, sel_valid);
	modport dec (input analog_only, chan_sel, gch_en, conv_en, href_en,
		output ain_sel, dig_ok, href_conn, sel_valid);
endinterface : pasm_sel_if

/* verilog/pasm_pin_decode.sv */
`timescale 1ns/1ps
// Purpose: per-pin function decode of the share mux
// Assumes: configuration arrives already registered
// Notes:   purely combinational
module pasm_pin_decode #(
	parameter int NPINS = 5
) (
	pasm_sel_if.dec s
);
	if (NPINS < 1 || NPINS > 6) begin : g_bad_npins
		$error("pasm_pin_decode: NPINS out of range");
	end
	logic sel_in_range;
	always_comb begin
		sel_in_range = (s.chan_sel <= pasm_pkg::PASM_SEL_MAX); // [R7]
		s.sel_valid  = sel_in_range;
		s.href_conn  = s.href_en; // [R9]
	end
	genvar g;
	generate
		for (g = 0; g < NPINS; g++) begin : g_pin
			logic hit;
			logic href_here;
			always_comb begin
				// undefined selector codes route nothing
				hit          = sel_in_range && (s.chan_sel == 3'(g)); // [R8] [R1]
				href_here    = (g == 0) && s.href_en;
				s.ain_sel[g] = s.conv_en && s.gch_en && hit && !href_here; // [R12] [R6] [R5]
				s.dig_ok[g]  = !s.analog_only[g] && !(s.gch_en && hit) && !href_here; // [R2] [R3]
			end
		end
	endgenerate
endmodule : pasm_pin_decode

/* verilog/pasm_top.sv */
`timescale 1ns/1ps
// Purpose: port-4 digital/analog/reference pin selection with axi4-lite registers
// Assumes: aclk 40 MHz, synchronous active-low reset
// Notes:   pad levels arrive asynchronously and are filtered
module pasm_top #(
	parameter int NPINS = 5
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [9:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [9:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	input  wire logic [NPINS-1:0] pad_in,
	output logic [NPINS-1:0]      pad_out,
	output logic [NPINS-1:0]      pad_oe,
	output logic [NPINS-1:0]      pad_dig_in_en,
	output logic [NPINS-1:0]      analog_input_sel,
	output logic                  external_high_ref_pin_conn
);
	if (NPINS != pasm_pkg::PASM_NPINS) begin : g_bad_npins
		$error("pasm_top: NPINS must equal the port width");
	end

	logic [NPINS-1:0] port4_analog_only_cfg_r;
	logic [7:0]       converter_high_ref_cfg_r;
	logic [7:0]       converter_mode_channel_r;
	logic [NPINS-1:0] port4_data_r;
	logic [NPINS-1:0] port4_direction_r;
	logic [NPINS-1:0] sync1_r;
	logic [NPINS-1:0] sync2_r;
	logic [NPINS-1:0] sync3_r;
	logic [NPINS-1:0] pin_level_r;
	logic             aw_held_r;
	logic             w_held_r;
	logic [9:0]       aw_addr_r;
	logic [31:0]      w_data_r;
	logic [3:0]       w_strb_r;

	pasm_sel_if #(.NPINS(NPINS)) sel ();

	assign sel.analog_only = port4_analog_only_cfg_r;
	assign sel.chan_sel    = converter_mode_channel_r[2:0];
	assign sel.gch_en      = converter_mode_channel_r[pasm_pkg::PASM_MODE_GCH_BIT];
	assign sel.conv_en     = converter_mode_channel_r[pasm_pkg::PASM_MODE_CONV_BIT];
	assign sel.href_en     = converter_high_ref_cfg_r[pasm_pkg::PASM_HREF_EN_BIT];

	pasm_pin_decode #(.NPINS(NPINS)) u_dec (
		.s (sel.dec)
	);

	// printed offsets are indexes, so the byte address is four times one
	function automatic logic [7:0] word_idx(input logic [9:0] a);
		word_idx = a[9:2];
	endfunction : word_idx

	function automatic logic is_mapped(input logic [7:0] idx);
		case (idx)
			pasm_pkg::PASM_IDX_ANALOG,
			pasm_pkg::PASM_IDX_HREF,
			pasm_pkg::PASM_IDX_MODE,
			pasm_pkg::PASM_IDX_DATA,
			pasm_pkg::PASM_IDX_DIR,
			pasm_pkg::PASM_IDX_STATUS: is_mapped = 1'b1;
			default:                   is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// write channel: address and data captured separately, either order
	logic do_write;
	logic [7:0] wr_idx;
	assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_idx   = word_idx(aw_addr_r);

	// bvalid holds both readies low, so a second write waits for the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r     <= 1'b0;
			s_axi_awready <= 1'b0;
			aw_addr_r     <= 10'h000;
		end else if (do_write) begin
			aw_held_r     <= 1'b0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r     <= 1'b1;
			aw_addr_r     <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r     <= 1'b0;
			s_axi_wready <= 1'b0;
			w_data_r     <= 32'h0000_0000;
			w_strb_r     <= 4'h0;
		end else if (do_write) begin
			w_held_r     <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r     <= 1'b1;
			w_data_r     <= s_axi_wdata;
			w_strb_r     <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_r && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= pasm_pkg::PASM_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(wr_idx) ? pasm_pkg::PASM_RESP_OKAY
				: pasm_pkg::PASM_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// only byte lane 0 carries register bits
	logic wr_lane0;
	assign wr_lane0 = do_write && w_strb_r[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port4_analog_only_cfg_r <= pasm_pkg::PASM_RESET_VAL[NPINS-1:0]; // [R4]
		end else if (wr_lane0 && wr_idx == pasm_pkg::PASM_IDX_ANALOG) begin
			port4_analog_only_cfg_r <= w_data_r[NPINS-1:0]; // [R4]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			converter_high_ref_cfg_r <= pasm_pkg::PASM_RESET_VAL;
		end else if (wr_lane0 && wr_idx == pasm_pkg::PASM_IDX_HREF) begin
			converter_high_ref_cfg_r <= w_data_r[7:0] & pasm_pkg::PASM_HREF_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			converter_mode_channel_r <= pasm_pkg::PASM_RESET_VAL;
		end else if (wr_lane0 && wr_idx == pasm_pkg::PASM_IDX_MODE) begin
			converter_mode_channel_r <= w_data_r[7:0] & pasm_pkg::PASM_MODE_MASK;
		end
	end

	// software orders latch before direction, so no glitch logic here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port4_data_r <= '0;
		end else if (wr_lane0 && wr_idx == pasm_pkg::PASM_IDX_DATA) begin
			port4_data_r <= w_data_r[NPINS-1:0]; // [R11]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port4_direction_r <= '0;
		end else if (wr_lane0 && wr_idx == pasm_pkg::PASM_IDX_DIR) begin
			port4_direction_r <= w_data_r[NPINS-1:0];
		end
	end

	// pad synchroniser: three stages, the first may go metastable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end else begin
			sync1_r <= pad_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// level accepted once stages two and three agree, so a one-edge glitch is ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_level_r <= '0;
		end else begin
			for (int i = 0; i < NPINS; i++) begin
				if (sync2_r[i] == sync3_r[i])
					pin_level_r[i] <= sync3_r[i];
			end
		end
	end

	// pad controls registered; digital path dropped when not digital-capable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_out <= '0;
		end else begin
			pad_out <= port4_data_r & sel.dig_ok; // [R2]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_oe <= '0;
		end else begin
			pad_oe <= port4_direction_r & sel.dig_ok; // [R13] [R2] [R10]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_dig_in_en <= '0;
		end else begin
			pad_dig_in_en <= sel.dig_ok & ~port4_direction_r; // [R13]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_input_sel <= '0;
		end else begin
			analog_input_sel <= sel.ain_sel; // [R1] [R12]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			external_high_ref_pin_conn <= 1'b0;
		end else begin
			external_high_ref_pin_conn <= sel.href_conn; // [R9]
		end
	end

	// read path: one outstanding read, answer one cycle after acceptance
	logic [7:0]       rd_idx;
	logic [31:0]      rd_word;
	logic [NPINS-1:0] rd_port;
	assign rd_idx = word_idx(s_axi_araddr);

	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			// output pins read back their latch; isolated ones read a constant
			if (!sel.dig_ok[i])
				rd_port[i] = pasm_pkg::PASM_ISOLATED_READ; // [R14]
			else if (port4_direction_r[i])
				rd_port[i] = port4_data_r[i];
			else
				rd_port[i] = pin_level_r[i];
		end
		rd_word = 32'h0000_0000;
		case (rd_idx)
			pasm_pkg::PASM_IDX_ANALOG: rd_word[NPINS-1:0] = port4_analog_only_cfg_r;
			pasm_pkg::PASM_IDX_HREF:   rd_word[7:0] = converter_high_ref_cfg_r;
			pasm_pkg::PASM_IDX_MODE:   rd_word[7:0] = converter_mode_channel_r;
			pasm_pkg::PASM_IDX_DATA:   rd_word[NPINS-1:0] = rd_port;
			pasm_pkg::PASM_IDX_DIR:    rd_word[NPINS-1:0] = port4_direction_r;
			pasm_pkg::PASM_IDX_STATUS: rd_word[NPINS:0] = {sel.sel_valid, sel.ain_sel};
			default:                   rd_word = 32'h0000_0000;
		endcase
	end

	// arready rests one cycle after the answer, so one read is ever outstanding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= pasm_pkg::PASM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= is_mapped(rd_idx) ? pasm_pkg::PASM_RESP_OKAY
				: pasm_pkg::PASM_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : pasm_top

/* test/pasm_top_monitor.sv */
// Purpose: port-level checks of the share mux
// Assumes: one clock, synchronous active-low reset
// Notes:   sees top ports only, so selector range is left to the bench
`timescale 1ns/1ps
module pasm_top_monitor #(parameter int NPINS = 5) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic [31:0]      s_axi_rdata,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic [NPINS-1:0] pad_oe,
	input wire logic [NPINS-1:0] pad_dig_in_en,
	input wire logic [NPINS-1:0] analog_input_sel,
	input wire logic             external_high_ref_pin_conn
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_one_channel: assert property ($onehot0(analog_input_sel))
		else $error("more than one pin routed to converter");
	a_analog_isolated: assert property ((analog_input_sel & (pad_oe | pad_dig_in_en)) == '0)
		else $error("routed pin still digital");
	a_ref_takes_pin: assert property (external_high_ref_pin_conn |->
		!pad_oe[0] && !pad_dig_in_en[0] && !analog_input_sel[0])
		else $error("pin 0 shared with reference");
	a_dir_exclusive: assert property ((pad_oe & pad_dig_in_en) == '0)
		else $error("driver and input buffer both on");
	a_resp_follows: assert property (s_wr_both |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	// reset itself is the antecedent, so this one must not be disabled by it
	a_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
		analog_input_sel == '0 && pad_oe == '0 && !external_high_ref_pin_conn)
		else $error("pins not digital after reset");
endmodule : pasm_top_monitor

/* test/pasm_src_model.sv */
// Purpose: analog sources and reference on the far side of the pins
// Assumes: sources always drive, no pull resistors
// Notes:   a driven pin shows the device level instead of the source
`timescale 1ns/1ps
module pasm_src_model #(parameter int NPINS = 5) (
	input wire logic [NPINS-1:0] pad_oe,
	input wire logic [NPINS-1:0] pad_out,
	input wire logic [NPINS-1:0] src_lvl,
	output logic [NPINS-1:0]     pad_in
);
	always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & src_lvl);
endmodule : pasm_src_model

/* test/tb_port4_analog_share_mux.sv */
// Purpose: self-checking bench of the share mux
// Assumes: 40 MHz aclk, axi4-lite master driven at rising edges
// Notes:   byte address is the whole index shifted by two
`timescale 1ns/1ps
module tb_port4_analog_share_mux;
	typedef struct packed {
		logic [7:0] aon; logic [7:0] href; logic [7:0] mode; logic [7:0] dir;
		logic [4:0] oe; logic [4:0] din; logic [4:0] sel; logic conn;
	} pasm_row_t;
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        external_high_ref_pin_conn;
	logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [4:0]  pad_in, pad_out, pad_oe, pad_dig_in_en, analog_input_sel, lvl = 5'h0a;
	int          err_count = 0, cmp_count = 0;
	pasm_row_t   rows [9] = '{
		'{8'h00, 8'h00, 8'h00, 8'h1f, 5'h1f, 5'h00, 5'h00, 1'b0},
		'{8'h00, 8'h00, 8'h10, 8'h1f, 5'h1e, 5'h00, 5'h00, 1'b0},
		'{8'h00, 8'h00, 8'h93, 8'h0f, 5'h07, 5'h10, 5'h08, 1'b0},
		'{8'h03, 8'h00, 8'h94, 8'h00, 5'h00, 5'h0c, 5'h10, 1'b0},
		'{8'h00, 8'h80, 8'h90, 8'h1f, 5'h1e, 5'h00, 5'h00, 1'b1},
		'{8'h00, 8'h00, 8'h95, 8'h00, 5'h00, 5'h1f, 5'h00, 1'b0},
		'{8'h00, 8'h00, 8'h97, 8'h00, 5'h00, 5'h1f, 5'h00, 1'b0},
		'{8'h00, 8'h00, 8'h91, 8'h1f, 5'h1d, 5'h00, 5'h02, 1'b0},
		'{8'h00, 8'h00, 8'h92, 8'h00, 5'h00, 5'h1b, 5'h04, 1'b0}};
	always #12.5 aclk = ~aclk;
	pasm_top #(.NPINS(5)) u_pasm_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe,
		.pad_dig_in_en, .analog_input_sel, .external_high_ref_pin_conn);
	pasm_src_model #(.NPINS(5)) u_pasm_src_model (.pad_oe, .pad_out, .src_lvl(lvl), .pad_in);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(a && w)) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) a = 1'b1;
			if (s_axi_wready === 1'b1) w = 1'b1;
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(pasm_pkg::PASM_IDX_ANALOG, 32'h0, 2'h0);
		rd(pasm_pkg::PASM_IDX_MODE, 32'h0, 2'h0);
		foreach (rows[i]) begin
			wr(pasm_pkg::PASM_IDX_MODE, 8'h00, 2'h0);
			wr(pasm_pkg::PASM_IDX_ANALOG, rows[i].aon, 2'h0);
			wr(pasm_pkg::PASM_IDX_HREF, rows[i].href, 2'h0);
			wr(pasm_pkg::PASM_IDX_DIR, rows[i].dir, 2'h0);
			wr(pasm_pkg::PASM_IDX_MODE, rows[i].mode, 2'h0);
			repeat (2) @(posedge aclk);
			chk(pad_oe, rows[i].oe);
			chk(pad_dig_in_en, rows[i].din);
			chk(analog_input_sel, rows[i].sel);
			chk(external_high_ref_pin_conn, rows[i].conn);
		end
		rd(pasm_pkg::PASM_IDX_STATUS, 32'h24, 2'h0);
		wr(pasm_pkg::PASM_IDX_MODE, 8'hff, 2'h0);
		rd(pasm_pkg::PASM_IDX_MODE, 32'hf7, 2'h0);
		rd(pasm_pkg::PASM_IDX_STATUS, 32'h00, 2'h0);
		wr(pasm_pkg::PASM_IDX_MODE, 8'h00, 2'h0);
		wr(8'h10, 8'h55, 2'h2);
		rd(8'h10, 32'h0, 2'h2);
		wr(pasm_pkg::PASM_IDX_ANALOG, 8'hff, 2'h0);
		rd(pasm_pkg::PASM_IDX_ANALOG, 32'h1f, 2'h0);
		// synchroniser needs a few edges before the pad level shows
		repeat (5) @(posedge aclk);
		rd(pasm_pkg::PASM_IDX_DATA, 32'h0, 2'h0);
		wr(pasm_pkg::PASM_IDX_ANALOG, 8'h00, 2'h0);
		repeat (5) @(posedge aclk);
		rd(pasm_pkg::PASM_IDX_DATA, 32'h0a, 2'h0);
		wr(pasm_pkg::PASM_IDX_DATA, 8'h15, 2'h0);
		wr(pasm_pkg::PASM_IDX_DIR, 8'h1f, 2'h0);
		repeat (2) @(posedge aclk);
		chk(pad_out, 5'h15);
		rd(pasm_pkg::PASM_IDX_DATA, 32'h15, 2'h0);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(pasm_pkg::PASM_IDX_DIR, 32'h0, 2'h0);
		chk(pad_oe, 5'h00);
		wrap_up();
	end
	initial begin
		repeat (5000) @(posedge aclk);
		err_count++;
		wrap_up();
	end
endmodule : tb_port4_analog_share_mux
bind pasm_top pasm_top_monitor #(.NPINS(NPINS)) u_pasm_top_monitor (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pad_oe, .pad_dig_in_en,
	.analog_input_sel, .external_high_ref_pin_conn);
